// ===== bench/flash_array_model.sv
`timescale 1ns/1ps
module flash_array_model (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire       arr_start,
  input  wire [3:0] lat,
  output reg        arr_done
);
  reg [3:0] cnt_r;
  reg       run_r;
  // lat sets the finish delay: done comes lat+2 cycles after start, lat from 0 to 15
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      run_r <= 1'b0;
      arr_done <= 1'b0;
    end else begin
      arr_done <= 1'b0;
      if (arr_start) begin
        run_r <= 1'b1;
        cnt_r <= lat;
      end else if (run_r) begin
        if (cnt_r == 4'h0) begin
          run_r <= 1'b0;
          arr_done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 4'h1;
        end
      end
    end
  end
endmodule

// ===== bench/flash_unlock_props.sv
`timescale 1ns/1ps
`include "flash_unlock_defs.vh"
module flash_unlock_props (
  input wire               clk_sys,
  input wire               rst,
  input wire [`ADDR_W-1:0] reg_addr,
  input wire               reg_rd,
  input wire [7:0]         reg_rdata,
  input wire               dbg_access,
  input wire               flash_wr,
  input wire [15:0]        flash_addr,
  input wire               flash_busy,
  input wire               arr_start,
  input wire [1:0]         arr_op,
  input wire [15:0]        arr_addr,
  input wire [7:0]         arr_data,
  input wire               arr_info,
  input wire [7:0]         flash_wdata,
  input wire               arr_done
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_start_pulse: assert property (arr_start |=> !arr_start)
    else $error("start too long");
  a_start_busy: assert property (arr_start |-> flash_busy)
    else $error("start not busy");
  a_done_idle: assert property (flash_busy && arr_done |=> !flash_busy)
    else $error("busy after done");
  a_erase_ones: assert property (
    arr_start && arr_op != `OP_PROG |-> arr_data == 8'hff)
    else $error("erase data");
  a_page_base: assert property (
    arr_start && arr_op == `OP_PAGE_ERASE |-> arr_addr[8:0] == 9'h000)
    else $error("page base");
  a_mass_dbg: assert property (
    arr_start && arr_op == `OP_MASS_ERASE |-> $past(dbg_access))
    else $error("mass from user");
  a_prog_addr: assert property (
    arr_start && arr_op == `OP_PROG |->
    $past(flash_wr) && arr_addr == $past(flash_addr))
    else $error("prog addr");
  a_prog_data: assert property (
    arr_start && arr_op == `OP_PROG |-> arr_data == $past(flash_wdata))
    else $error("prog data");
  a_info_top: assert property (
    arr_start && arr_op == `OP_PROG && arr_info |->
    arr_addr[15:9] == 7'h7f)
    else $error("info outside top page");
  a_stat_top: assert property (
    $past(reg_rd) && $past(reg_addr) == `ADDR_CMD_STATE |->
    reg_rdata[7:6] == 2'b00)
    else $error("status top bits");
endmodule
bind flash_command_unlock_controller flash_unlock_props chk_u (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dbg_access(dbg_access), .flash_wr(flash_wr),
  .flash_addr(flash_addr), .flash_busy(flash_busy),
  .arr_start(arr_start), .arr_op(arr_op), .arr_addr(arr_addr),
  .arr_data(arr_data), .arr_info(arr_info), .flash_wdata(flash_wdata),
  .arr_done(arr_done));

// ===== bench/testbench.sv
`timescale 1ns/1ps
`include "flash_unlock_defs.vh"
module testbench;
  localparam [11:0] CA = `ADDR_CMD_STATE;
  localparam [11:0] PA = `ADDR_PAGE_SECTOR;
  reg         clk_sys = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] reg_addr = 12'h000;
  reg         reg_wr = 1'b0;
  reg         reg_rd = 1'b0;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         dbg_access = 1'b0;
  reg         wp = 1'b0;
  reg         flash_wr = 1'b0;
  reg  [15:0] flash_addr = 16'h0000;
  reg  [3:0]  lat = 4'h0;
  wire [7:0]  reg_rdata;
  wire        flash_busy;
  wire        arr_start;
  wire        arr_done;
  integer     n_fail = 0;
  integer     num_checks = 0;
  integer     n_start = 0;
  integer     cyc = 0;
  always #25 clk_sys = ~clk_sys;
  flash_command_unlock_controller dut_u (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .dbg_access(dbg_access), .write_protect_opt(wp),
    .flash_wr(flash_wr), .flash_addr(flash_addr), .flash_wdata(8'h5a),
    .flash_busy(flash_busy), .arr_start(arr_start), .arr_op(),
    .arr_addr(), .arr_data(), .arr_info(), .arr_done(arr_done));
  flash_array_model arr_u (.clk_sys(clk_sys), .rst(rst),
    .arr_start(arr_start), .lat(lat), .arr_done(arr_done));
  task report_and_stop;
    begin
      if (n_fail == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // run takes under 200 cycles; ceiling well above
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (arr_start) n_start <= n_start + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [7:0] e);
    begin
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk_sys);
      reg_rd = 1'b0;
      chk(reg_rdata, e);
    end
  endtask
  task idle;
    integer k;
    begin
      for (k = 0; k < 40 && flash_busy !== 1'b0; k = k + 1)
        @(negedge clk_sys);
    end
  endtask
  task fwr(input [15:0] a);
    begin
      @(negedge clk_sys);
      flash_addr = a;
      flash_wr = 1'b1;
      @(negedge clk_sys);
      flash_wr = 1'b0;
      idle;
    end
  endtask
  // leaves the second page write to the caller
  task unlock(input [7:0] p);
    begin
      wr(CA, `CMD_RESET);
      wr(PA, p);
      wr(CA, `CMD_UNLOCK_1);
      wr(CA, `CMD_UNLOCK_2);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    rd(CA, 8'h00);
    rd(PA, 8'h00);
    rd(12'h100, 8'h00);
    wr(CA, `CMD_RESET);
    wr(PA, 8'h05);
    wr(CA, `CMD_UNLOCK_1);
    rd(CA, 8'h01);
    wr(CA, `CMD_UNLOCK_2);
    rd(CA, 8'h02);
    wr(PA, 8'h05);
    rd(CA, 8'h03);
    fwr(16'h0000);
    chk(n_start, 0);
    fwr(16'h0a10);
    chk(n_start, 1);
    lat = 4'h6;
    wr(CA, `CMD_PAGE_ERASE);
    rd(CA, 8'h10);
    idle;
    rd(CA, 8'h00);
    chk(n_start, 2);
    unlock(8'h05);
    wr(CA, 8'h11);
    rd(CA, 8'h00);
    wr(CA, `CMD_MASS_ERASE);
    rd(CA, 8'h00);
    wr(CA, `CMD_SECTOR_SEL);
    rd(CA, 8'h04);
    wr(PA, 8'h01);
    wr(PA, 8'h02);
    rd(PA, 8'h03);
    dbg_access = 1'b1;
    wr(PA, 8'h01);
    rd(PA, 8'h01);
    dbg_access = 1'b0;
    wr(CA, `CMD_RESET);
    rd(PA, 8'h05);
    unlock(8'h00);
    wr(PA, 8'h00);
    fwr(16'h0010);
    chk(n_start, 2);
    dbg_access = 1'b1;
    fwr(16'h0010);
    chk(n_start, 3);
    fwr(16'h4000);
    chk(n_start, 4);
    wp = 1'b1;
    fwr(16'h4002);
    chk(n_start, 5);
    dbg_access = 1'b0;
    unlock(8'h20);
    wr(PA, 8'h20);
    fwr(16'h4004);
    chk(n_start, 5);
    wp = 1'b0;
    dbg_access = 1'b1;
    wr(PA, 8'h21);
    rd(CA, 8'h03);
    unlock(8'h21);
    rd(CA, 8'h03);
    wr(CA, `CMD_MASS_ERASE);
    idle;
    chk(n_start, 6);
    rd(CA, 8'h00);
    report_and_stop;
  end
endmodule

// ===== rtl/flash_command_unlock_controller.v
`timescale 1ns/1ps
`include "flash_unlock_defs.vh"

module flash_command_unlock_controller (
  input  wire                clk_sys,
  input  wire                rst,
  input  wire [`ADDR_W-1:0]  reg_addr,
  input  wire                reg_wr,
  input  wire                reg_rd,
  input  wire [7:0]          reg_wdata,
  output reg  [7:0]          reg_rdata,
  input  wire                dbg_access,
  input  wire                write_protect_opt,
  input  wire                flash_wr,
  input  wire [15:0]         flash_addr,
  input  wire [7:0]          flash_wdata,
  output wire                flash_busy,
  output reg                 arr_start,
  output reg  [1:0]          arr_op,
  output reg  [15:0]         arr_addr,
  output reg  [7:0]          arr_data,
  output reg                 arr_info,
  input  wire                arr_done
);

  reg [`ST_W-1:0] state_r;
  reg [`ST_W-1:0] state_nxt;
  reg [7:0]       page_choice_r;
  reg [7:0]       page_choice_nxt;
  reg [7:0]       sector_lock_r;
  reg [7:0]       sector_lock_nxt;
  reg             start_nxt;
  reg [1:0]       op_nxt;
  reg [15:0]      addr_nxt;
  reg [7:0]       data_nxt;
  reg             info_nxt;
  reg [7:0]       rdata_nxt;

  wire cmd_wr;
  wire page_wr;
  wire busy;
  wire flash_in_page;
  wire flash_in_info;
  wire prog_ok;
  wire page_erase_ok;
  wire [7:0] flash_state_reg;
  wire [7:0] sect_open;
  wire [7:0] lock_wr_val;

  // register address match, shared by the write and read paths
  function addr_is;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // flash address bits 15:9 against a seven-bit page number
  function page_hit;
    input [15:0] faddr;
    input [6:0]  page;
    begin
      page_hit = (faddr[`FADDR_PAGE_MSB:`FADDR_PAGE_LSB] == page);
    end
  endfunction

  // state codes of an array operation in flight
  function busy_code;
    input [`ST_W-1:0] st;
    begin
      case (st)
        `ST_PROG:       busy_code = 1'b1;
        `ST_PAGE_ERASE: busy_code = 1'b1;
        `ST_MASS_ERASE: busy_code = 1'b1;
        default:        busy_code = 1'b0;
      endcase
    end
  endfunction

  // one open flag and one next lock bit per sector
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sector
      // debug ignores both the option bit and the locks
      assign sect_open[gi] =
        dbg_access ||
        (!write_protect_opt && !sector_lock_r[gi]);
      // user can only add protection, debug may also remove it
      assign lock_wr_val[gi] =
        dbg_access ? reg_wdata[gi] :
        (sector_lock_r[gi] | reg_wdata[gi]);
    end
  endgenerate

  assign cmd_wr  = reg_wr && addr_is(reg_addr, `ADDR_CMD_STATE);
  assign page_wr = reg_wr && addr_is(reg_addr, `ADDR_PAGE_SECTOR);

  // busy derived from state, so status and busy never disagree
  assign busy       = busy_code(state_r);
  assign flash_busy = busy;

  // upper two bits always zero, low six bits carry the state code
  assign flash_state_reg = {2'b00, state_r};

  assign flash_in_page =
    page_hit(flash_addr, page_choice_r[`PAGE_MSB:0]);

  assign flash_in_info =
    page_choice_r[`PAGE_INFO_BIT] &&
    page_hit(flash_addr, `INFO_BASE_PAGE);

  // sector is address bits 15:13, or page bits 6:4 for an erase
  assign prog_ok =
    (dbg_access || flash_in_page) &&
    sect_open[flash_addr[`FADDR_SECT_MSB:`FADDR_SECT_LSB]];

  assign page_erase_ok =
    sect_open[page_choice_r[`PAGE_SECT_MSB:`PAGE_SECT_LSB]];

  always @* begin
    state_nxt       = state_r;
    page_choice_nxt = page_choice_r;
    sector_lock_nxt = sector_lock_r;
    start_nxt       = 1'b0;
    op_nxt          = arr_op;
    addr_nxt        = arr_addr;
    data_nxt        = arr_data;
    info_nxt        = arr_info;

    if (busy) begin
      // cpu idles while busy, so register and flash writes are dropped
      if (arr_done) begin
        case (state_r)
          `ST_PROG:       state_nxt = `ST_UNLOCKED;
          `ST_PAGE_ERASE: state_nxt = `ST_LOCKED;
          `ST_MASS_ERASE: state_nxt = `ST_LOCKED;
          default:        state_nxt = `ST_LOCKED;
        endcase
        op_nxt = `OP_NONE;
      end

    end else if (cmd_wr) begin
      // command codes are not stored; a read of this address returns the state
      case (reg_wdata)
        `CMD_UNLOCK_1: begin
          if (state_r == `ST_LOCKED)
            state_nxt = `ST_FIRST;
          else
            state_nxt = `ST_LOCKED;
        end

        `CMD_UNLOCK_2: begin
          if (state_r == `ST_FIRST && dbg_access)
            state_nxt = `ST_UNLOCKED;
          else if (state_r == `ST_FIRST)
            state_nxt = `ST_SECOND;
          else
            state_nxt = `ST_LOCKED;
        end

        `CMD_PAGE_ERASE: begin
          if (state_r == `ST_UNLOCKED && page_erase_ok) begin
            state_nxt = `ST_PAGE_ERASE;
            start_nxt = 1'b1;
            op_nxt    = `OP_PAGE_ERASE;
            addr_nxt  = {page_choice_r[`PAGE_MSB:0], 9'h000};
            data_nxt  = 8'hff;
            info_nxt  = page_choice_r[`PAGE_INFO_BIT];
          end else begin
            state_nxt = `ST_LOCKED;
          end
        end

        `CMD_MASS_ERASE: begin
          if (state_r == `ST_UNLOCKED && dbg_access) begin
            state_nxt = `ST_MASS_ERASE;
            start_nxt = 1'b1;
            op_nxt    = `OP_MASS_ERASE;
            addr_nxt  = 16'h0000;
            data_nxt  = 8'hff;
            info_nxt  = 1'b0;
          end else begin
            state_nxt = `ST_LOCKED;
          end
        end

        `CMD_SECTOR_SEL: state_nxt = `ST_SECTOR_SEL;
        default:         state_nxt = `ST_LOCKED;
      endcase

    end else if (page_wr) begin
      if (state_r == `ST_SECTOR_SEL) begin
        // page register stays hidden while selected
        sector_lock_nxt = lock_wr_val;
      end else begin
        case (state_r)
          `ST_LOCKED: page_choice_nxt = reg_wdata;

          `ST_SECOND: begin
            // only the same page may be reopened
            if (reg_wdata == page_choice_r)
              state_nxt = `ST_UNLOCKED;
            else
              state_nxt = `ST_LOCKED;
          end

          `ST_UNLOCKED: begin
            if (dbg_access) begin
              page_choice_nxt = reg_wdata;
            end else begin
              page_choice_nxt = reg_wdata;
              state_nxt       = `ST_LOCKED;
            end
          end

          default: begin
            page_choice_nxt = reg_wdata;
            state_nxt       = `ST_LOCKED;
          end
        endcase
      end

    end else if (flash_wr && state_r == `ST_UNLOCKED) begin
      // writes that fail the checks vanish silently
      if (prog_ok) begin
        state_nxt = `ST_PROG;
        start_nxt = 1'b1;
        op_nxt    = `OP_PROG;
        addr_nxt  = flash_addr;
        data_nxt  = flash_wdata;
        info_nxt  = flash_in_info;
      end
    end
  end

  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r       <= `RST_STATE;
      page_choice_r <= `RST_PAGE;
      sector_lock_r <= `RST_SECTOR;
      arr_start     <= 1'b0;
      arr_op        <= `OP_NONE;
      arr_addr      <= 16'h0000;
      arr_data      <= 8'h00;
      arr_info      <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      page_choice_r <= page_choice_nxt;
      sector_lock_r <= sector_lock_nxt;
      arr_start     <= start_nxt;
      arr_op        <= op_nxt;
      arr_addr      <= addr_nxt;
      arr_data      <= data_nxt;
      arr_info      <= info_nxt;
    end
  end

  // read mux; reads change no state, unmapped reads give zero
  always @* begin
    rdata_nxt = 8'h00;
    if (addr_is(reg_addr, `ADDR_CMD_STATE)) begin
      rdata_nxt = flash_state_reg;
    end else if (addr_is(reg_addr, `ADDR_PAGE_SECTOR)) begin
      if (state_r == `ST_SECTOR_SEL)
        rdata_nxt = sector_lock_r;
      else
        rdata_nxt = page_choice_r;
    end
  end

  // read data registered and held until the next read
  always @(posedge clk_sys or posedge rst) begin
    if (rst)
      reg_rdata <= `RST_RDATA;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
  end

endmodule

// ===== rtl/flash_unlock_defs.vh
`ifndef FLASH_UNLOCK_DEFS_VH
`define FLASH_UNLOCK_DEFS_VH

// register file addresses
`define ADDR_W            12
`define ADDR_CMD_STATE    12'hff8
`define ADDR_PAGE_SECTOR  12'hff9

// command codes
`define CMD_RESET         8'h00
`define CMD_UNLOCK_1      8'h73
`define CMD_UNLOCK_2      8'h8c
`define CMD_PAGE_ERASE    8'h95
`define CMD_MASS_ERASE    8'h63
`define CMD_SECTOR_SEL    8'h5e

// controller state field values
`define ST_W              6
`define ST_LOCKED         6'h00
`define ST_FIRST          6'h01
`define ST_SECOND         6'h02
`define ST_UNLOCKED       6'h03
`define ST_SECTOR_SEL     6'h04
`define ST_PROG           6'h08
`define ST_PAGE_ERASE     6'h10
`define ST_MASS_ERASE     6'h20

// reset values
`define RST_STATE         6'h00
`define RST_PAGE          8'h00
`define RST_SECTOR        8'h00
`define RST_RDATA         8'h00

// page select fields
`define PAGE_INFO_BIT     7
`define PAGE_MSB          6
`define FADDR_PAGE_MSB    15
`define FADDR_PAGE_LSB    9
`define FADDR_SECT_MSB    15
`define FADDR_SECT_LSB    13
`define PAGE_SECT_MSB     6
`define PAGE_SECT_LSB     4
`define INFO_BASE_PAGE    7'h7f

// array operation codes
`define OP_PROG           2'h1
`define OP_PAGE_ERASE     2'h2
`define OP_MASS_ERASE     2'h3
`define OP_NONE           2'h0

`endif
